/* File: rtl/typeb_tx_edge_shaper.sv */
/*
  Type B transmit envelope shaper with its Wishbone register file.
  Assumes each clk cycle is one RF carrier cycle, mod_req comes from
  the bit coder on clk, and the supply level arrives asynchronously.
*/
// Functional notes
// - Type B shaping, floor and kind set per bit rate; shape and length shared
// - Falling bits 6:4 give time constant
// - Lookup styles: falling bits pick table
// - Rising bits 2:0 give time constant
// - Lookup styles: rising bits pick table
// - Length bit 7 doubles each state
// - Length bits 4:0 count states
// - Floor level sets modulated amplitude
// - Codes 1-3: one, two, three ramps
// - Falling code in kind bits 7:4
// - Codes 4-6: table, adapted, uncorrected
// - Rising code in kind bits 3:0
`timescale 1ns/100ps
module typeb_tx_edge_shaper (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Modulation and supply
  input  wire logic        mod_req,
  input  wire logic [7:0]  amplifier_supply_voltage,
  // Amplifier drive
  output logic      [7:0]  tx_amplitude,
  output logic             edge_active
);

  // Register file
  logic [7:0]  resid106_reg;
  logic [7:0]  kind106_reg;
  logic [7:0]  shape106_reg;
  logic [7:0]  len106_reg;
  logic [7:0]  floor212_reg;
  logic [7:0]  kind212_reg;
  logic [7:0]  ctrl_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;

  // Supply synchroniser
  logic [7:0]  supply_meta_reg;
  logic [7:0]  supply_sync_reg;
  logic [7:0]  supply_hold_reg;
  logic [7:0]  supply_use_reg;

  // Shaper state
  shape_pkg::shape_state_t state_reg;
  shape_pkg::shape_state_t state_next;
  logic [4:0]  step_reg;
  logic [4:0]  step_next;
  logic        dwell_reg;
  logic        dwell_next;
  logic [7:0]  start_reg;
  logic [7:0]  start_next;
  logic [7:0]  amp_reg;
  logic [7:0]  amp_next;

  // Bus decode
  logic [5:0]  idx;
  logic        bus_req;
  logic        wr_en;
  logic        hit_resid;
  logic        hit_kind106;
  logic        hit_shape;
  logic        hit_len;
  logic        hit_floor;
  logic        hit_kind212;
  logic        hit_ctrl;
  logic        hit_status;
  logic [7:0]  rd_byte;
  logic [7:0]  status_byte;

  assign idx         = wb_adr_i[7:2];
  assign bus_req     = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr_en       = bus_req && wb_we_i && wb_sel_i[0];
  assign hit_resid   = (idx == shape_pkg::IDX_RESID_106);
  assign hit_kind106 = (idx == shape_pkg::IDX_KIND_106);
  assign hit_shape   = (idx == shape_pkg::IDX_SHAPE_106);
  assign hit_len     = (idx == shape_pkg::IDX_LEN_106);
  assign hit_floor   = (idx == shape_pkg::IDX_FLOOR_212);
  assign hit_kind212 = (idx == shape_pkg::IDX_KIND_212);
  assign hit_ctrl    = (idx == shape_pkg::IDX_CTRL);
  assign hit_status  = (idx == shape_pkg::IDX_STATUS);

  assign status_byte = {5'h00, edge_active, state_reg};

  // Unmapped words read as zero
  assign rd_byte = hit_resid   ? resid106_reg :
                   hit_kind106 ? kind106_reg  :
                   hit_shape   ? shape106_reg :
                   hit_len     ? len106_reg   :
                   hit_floor   ? floor212_reg :
                   hit_kind212 ? kind212_reg  :
                   hit_ctrl    ? ctrl_reg     :
                   hit_status  ? status_byte  : 8'h00;

  always_ff @(posedge clk) begin
    if (reset) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg   <= bus_req;
      rdata_reg <= bus_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      resid106_reg <= shape_pkg::RST_RESID;
      kind106_reg  <= shape_pkg::RST_KIND;
      shape106_reg <= shape_pkg::RST_SHAPE;
      len106_reg   <= shape_pkg::RST_LEN;
      floor212_reg <= shape_pkg::RST_RESID;
      kind212_reg  <= shape_pkg::RST_KIND;
      ctrl_reg     <= shape_pkg::RST_CTRL;
    end else if (wr_en) begin
      if (hit_resid) begin
        resid106_reg <= wb_dat_i[7:0];
      end
      if (hit_kind106) begin
        kind106_reg <= wb_dat_i[7:0];
      end
      if (hit_shape) begin
        shape106_reg <= wb_dat_i[7:0] & shape_pkg::SHAPE_MASK;
      end
      if (hit_len) begin
        len106_reg <= wb_dat_i[7:0] & shape_pkg::LEN_MASK;
      end
      if (hit_floor) begin
        floor212_reg <= wb_dat_i[7:0];
      end
      if (hit_kind212) begin
        kind212_reg <= wb_dat_i[7:0];
      end
      if (hit_ctrl) begin
        ctrl_reg <= wb_dat_i[7:0] & shape_pkg::CTRL_MASK;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      supply_meta_reg <= 8'h00;
      supply_sync_reg <= 8'h00;
      supply_hold_reg <= 8'h00;
      supply_use_reg  <= 8'h00;
    end else begin
      supply_meta_reg <= amplifier_supply_voltage;
      supply_sync_reg <= supply_meta_reg;
      supply_hold_reg <= supply_sync_reg;
      // Word taken only when two samples agree, so no torn bits
      if (supply_sync_reg == supply_hold_reg) begin
        supply_use_reg <= supply_sync_reg;
      end
    end
  end

  // Active parameter set
  logic        shaping_en;
  logic        rate_212;
  logic [7:0]  floor_lvl;
  logic [7:0]  kind_sel;
  logic        falling;
  logic        in_edge;
  logic [3:0]  edge_code;
  logic [2:0]  edge_cfg;
  logic [4:0]  states_n;
  logic        len_x2;
  logic        step_now;
  logic        last_step;
  logic        mod_on;
  logic [12:0] pos_full;
  logic [8:0]  pos;
  logic [8:0]  frac;
  logic [7:0]  target;
  logic signed [9:0]  delta;
  logic signed [19:0] prod;
  logic [9:0]  shaped_sum;
  logic [7:0]  shaped;

  assign shaping_en = ctrl_reg[shape_pkg::CTRL_EN_BIT];
  assign rate_212   = ctrl_reg[shape_pkg::CTRL_RATE_BIT];
  assign floor_lvl  = rate_212 ? floor212_reg : resid106_reg;
  assign kind_sel   = rate_212 ? kind212_reg : kind106_reg;
  assign falling    = (state_reg == shape_pkg::ST_FALL);
  assign in_edge    = falling || (state_reg == shape_pkg::ST_RISE);
  assign mod_on     = shaping_en && mod_req;

  assign edge_code = falling ? kind_sel[shape_pkg::FALL_KIND_LO +: 4]
                             : kind_sel[shape_pkg::RISE_KIND_LO +: 4];
  assign edge_cfg  = falling ? shape106_reg[shape_pkg::FALL_CFG_LO +: 3]
                             : shape106_reg[shape_pkg::RISE_CFG_LO +: 3];

  assign states_n  = len106_reg[4:0];
  assign len_x2    = len106_reg[shape_pkg::LEN_X2_BIT];
  assign step_now  = in_edge && (!len_x2 || dwell_reg);
  assign last_step = (step_reg >= states_n);

  assign pos_full = {step_reg, 8'h00} / {8'h00, states_n};
  assign pos      = (states_n == 5'h00) ? shape_pkg::FRAC_ONE : pos_full[8:0];

  edge_frac u_edge_frac (
    .code   (edge_code),
    .cfg    (edge_cfg),
    .pos    (pos),
    .supply (supply_use_reg),
    .frac   (frac)
  );

  assign target     = falling ? floor_lvl : shape_pkg::FULL_AMP;
  assign delta      = $signed({2'b00, target}) - $signed({2'b00, start_reg});
  assign prod       = delta * $signed({1'b0, frac});
  assign shaped_sum = {2'b00, start_reg} + prod[17:8];
  assign shaped     = shaped_sum[7:0];

  always_comb begin
    state_next = state_reg;
    step_next  = step_reg;
    dwell_next = 1'b0;
    start_next = start_reg;
    amp_next   = amp_reg;
    case (state_reg)
      shape_pkg::ST_HIGH: begin
        amp_next = shape_pkg::FULL_AMP;
        if (mod_on) begin
          state_next = shape_pkg::ST_FALL;
          step_next  = 5'h01;
          start_next = amp_reg;
        end
      end
      shape_pkg::ST_LOW: begin
        amp_next = floor_lvl;
        if (!mod_on) begin
          state_next = shape_pkg::ST_RISE;
          step_next  = 5'h01;
          start_next = amp_reg;
        end
      end
      default: begin
        dwell_next = !dwell_reg && len_x2;
        if (step_now) begin
          amp_next = shaped;
          if (last_step) begin
            state_next = falling ? shape_pkg::ST_LOW : shape_pkg::ST_HIGH;
            amp_next   = target;
          end else begin
            step_next = step_reg + 5'h01;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= shape_pkg::ST_HIGH;
      step_reg  <= 5'h00;
      dwell_reg <= 1'b0;
      start_reg <= shape_pkg::FULL_AMP;
      amp_reg   <= shape_pkg::FULL_AMP;
    end else begin
      state_reg <= state_next;
      step_reg  <= step_next;
      dwell_reg <= dwell_next;
      start_reg <= start_next;
      amp_reg   <= amp_next;
    end
  end

  logic edge_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      edge_reg <= 1'b0;
    end else begin
      edge_reg <= (state_next == shape_pkg::ST_FALL) || (state_next == shape_pkg::ST_RISE);
    end
  end

  assign tx_amplitude = amp_reg;
  assign edge_active  = edge_reg;
  assign wb_ack_o     = ack_reg;
  assign wb_dat_o     = rdata_reg;

endmodule

/* File: common/shape_pkg.sv */
/*
  Constants and types for the Type B transmit edge shaper.
  Assumes a 32-bit classic Wishbone register bus, one register per word.
*/
package shape_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_RESID_106 = 6'h24;
  localparam logic [5:0] IDX_KIND_106  = 6'h25;
  localparam logic [5:0] IDX_SHAPE_106 = 6'h26;
  localparam logic [5:0] IDX_LEN_106   = 6'h27;
  localparam logic [5:0] IDX_FLOOR_212 = 6'h28;
  localparam logic [5:0] IDX_KIND_212  = 6'h29;
  localparam logic [5:0] IDX_CTRL      = 6'h30;
  localparam logic [5:0] IDX_STATUS    = 6'h31;

  // Writable bit masks; reserved bits store nothing and read zero
  localparam logic [7:0] SHAPE_MASK = 8'h77;
  localparam logic [7:0] LEN_MASK   = 8'h9F;
  localparam logic [7:0] CTRL_MASK  = 8'h03;

  // Field positions
  localparam int FALL_CFG_LO = 4;
  localparam int RISE_CFG_LO = 0;
  localparam int LEN_X2_BIT  = 7;
  localparam int FALL_KIND_LO = 4;
  localparam int RISE_KIND_LO = 0;
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_RATE_BIT = 1;

  // Reset values
  localparam logic [7:0] RST_RESID = 8'h00;
  localparam logic [7:0] RST_KIND  = 8'h11;
  localparam logic [7:0] RST_SHAPE = 8'h00;
  localparam logic [7:0] RST_LEN   = 8'h00;
  localparam logic [7:0] RST_CTRL  = 8'h00;

  // Edge style codes
  localparam logic [3:0] CODE_LIN1     = 4'h1;
  localparam logic [3:0] CODE_LIN2     = 4'h2;
  localparam logic [3:0] CODE_LIN3     = 4'h3;
  localparam logic [3:0] CODE_LUT      = 4'h4;
  localparam logic [3:0] CODE_LUT_CORR = 4'h5;
  localparam logic [3:0] CODE_LUT_RAW  = 4'h6;

  // Amplitude and progress scale
  localparam logic [7:0] FULL_AMP = 8'hFF;
  localparam logic [8:0] FRAC_ONE = 9'h100;
  localparam logic [8:0] KNEE_Q1  = 9'h040;
  localparam logic [8:0] KNEE_Q2  = 9'h080;
  localparam logic [8:0] KNEE_Q3  = 9'h0C0;

  typedef enum logic [1:0] {ST_HIGH, ST_FALL, ST_LOW, ST_RISE} shape_state_t;

endpackage

/* File: rtl/edge_frac.sv */
/*
  Maps edge progress to a shaped fraction of the amplitude step.
  Assumes pos runs 0..256 and supply is already synchronised.
*/
`timescale 1ns/100ps
module edge_frac (
  // Edge selection
  input  wire logic [3:0] code,
  input  wire logic [2:0] cfg,
  // Progress and supply
  input  wire logic [8:0] pos,
  input  wire logic [7:0] supply,
  // Shaped fraction, 256 is the full step
  output logic      [8:0] frac
);

  localparam logic [8:0] FRAC_ONE = shape_pkg::FRAC_ONE;
  localparam logic [8:0] KNEE_Q1  = shape_pkg::KNEE_Q1;
  localparam logic [8:0] KNEE_Q2  = shape_pkg::KNEE_Q2;
  localparam logic [8:0] KNEE_Q3  = shape_pkg::KNEE_Q3;
  localparam logic [7:0] FULL_AMP = shape_pkg::FULL_AMP;

  logic [8:0] lut [0:3][0:7];
  logic [8:0] knee;
  logic [8:0] half_knee;
  logic [8:0] tab;
  logic [17:0] p_lo;
  logic [17:0] p_mid2;
  logic [17:0] p_mid3;
  logic [17:0] p_hi;
  logic [17:0] scaled;
  logic [17:0] boost;
  logic [8:0] lin2;
  logic [8:0] lin3;

  assign lut[0] = '{9'h000, 9'h020, 9'h040, 9'h060, 9'h080, 9'h0A0, 9'h0C0, 9'h0E0};
  assign lut[1] = '{9'h000, 9'h008, 9'h020, 9'h050, 9'h0B0, 9'h0E0, 9'h0F8, 9'h0FE};
  assign lut[2] = '{9'h000, 9'h060, 9'h0A0, 9'h0C8, 9'h0E0, 9'h0F0, 9'h0F8, 9'h0FC};
  assign lut[3] = '{9'h000, 9'h004, 9'h010, 9'h020, 9'h038, 9'h060, 9'h098, 9'h0D0};

  // Time constant sets the knee height
  assign knee      = {2'b00, cfg, 4'h0} + 9'h010;
  assign half_knee = {1'b0, knee[8:1]};
  assign tab       = lut[cfg[1:0]][pos[7:5]];

  assign p_lo   = (18'(pos) * 18'(knee)) >> 7;
  assign p_mid2 = (18'(pos - KNEE_Q2) * 18'(FRAC_ONE - knee)) >> 7;
  assign p_mid3 = (18'(pos - KNEE_Q1) * 18'(FRAC_ONE - knee)) >> 7;
  assign p_hi   = (18'(pos - KNEE_Q3) * 18'(knee)) >> 7;
  assign scaled = (18'(tab) * (18'(supply) + 18'h00001)) >> 8;
  assign boost  = (18'(FRAC_ONE - tab) * 18'(FULL_AMP - supply)) >> 8;

  assign lin2 = (pos < KNEE_Q2) ? p_lo[8:0] : knee + p_mid2[8:0];
  assign lin3 = (pos < KNEE_Q1) ? p_lo[8:0] :
                (pos < KNEE_Q3) ? half_knee + p_mid3[8:0] :
                FRAC_ONE - half_knee + p_hi[8:0];

  always_comb begin
    if (pos >= FRAC_ONE) begin
      frac = FRAC_ONE;
    end else begin
      case (code)
        shape_pkg::CODE_LIN1:     frac = pos;
        shape_pkg::CODE_LIN2:     frac = lin2;
        shape_pkg::CODE_LIN3:     frac = lin3;
        shape_pkg::CODE_LUT:      frac = tab;
        shape_pkg::CODE_LUT_CORR: frac = tab + boost[8:0];
        shape_pkg::CODE_LUT_RAW:  frac = scaled[8:0];
        default:                  frac = FRAC_ONE;
      endcase
    end
  end

endmodule

/* File: test/pa_model.sv */
/*
  Behavioural power amplifier: turns drive into a supply level.
  Assumes the shaper's clk; the supply droops as drive rises.
*/
`timescale 1ns/100ps
module pa_model (
  // Clock
  input  wire logic       clk,
  // Drive in, supply out
  input  wire logic [7:0] tx_amplitude,
  output logic      [7:0] supply_level
);
  logic ripple = 1'b0;
  initial supply_level = 8'hD0;
  // Droop plus ripple so that the supply never sits still
  always_ff @(posedge clk) begin
    ripple       <= !ripple;
    supply_level <= 8'hD0 - {3'h0, tx_amplitude[7:3]} + {7'h00, ripple};
  end
endmodule

/* File: test/shaper_assertions.sv */
/*
  Port checker for the Type B edge shaper.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module shaper_assertions (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Bus
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o,
  // Shaping
  input  wire logic        mod_req,
  input  wire logic [7:0]  tx_amplitude,
  input  wire logic        edge_active
);
  logic [6:0] quiet_reg;
  // Cycles with no modulation request, saturating
  always_ff @(posedge clk) begin
    if (reset || mod_req) quiet_reg <= 7'h00;
    else if (quiet_reg != 7'h46) quiet_reg <= quiet_reg + 7'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data outside ack");
  data_upper_a: assert property (wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
  reset_state_a: assert property (disable iff (1'b0)
    reset |=> tx_amplitude == 8'hFF && !edge_active && !wb_ack_o)
    else $error("reset state wrong");
  quiet_carrier_a: assert property (quiet_reg == 7'h46 |-> tx_amplitude == 8'hFF)
    else $error("carrier not full when idle");
  ramp_bound_a: assert property ($rose(edge_active) |-> ##[1:64] !edge_active)
    else $error("edge ramp too long");
  ramp_seen_c: cover property ($fell(edge_active) && tx_amplitude != 8'hFF);
  rise_seen_c: cover property ($fell(edge_active) && tx_amplitude == 8'hFF);
  ack_seen_c: cover property (wb_ack_o);
endmodule

bind typeb_tx_edge_shaper shaper_assertions shaper_assertions_inst (
  .clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mod_req(mod_req),
  .tx_amplitude(tx_amplitude), .edge_active(edge_active));

/* File: test/testbench.sv */
/*
  Self-checking bench for the Type B edge shaper.
  Assumes a 25 MHz clk and the supply from the amplifier model.
*/
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, mod_req = 1'b0;
  logic [7:0] adr = 8'h00, d, fl, exp_r, amp, supply;
  logic [3:0] sel = 4'h0, code;
  logic [31:0] dat_w = 32'h0, dat_r;
  logic ack, act, prev_act = 1'b0, x2;
  logic [4:0] n5;
  logic [5:0] act_len = 6'h00;
  logic [15:0] seed = 16'h904B;
  logic [7:0] rq[$];
  logic [13:0] aq[$];
  logic [13:0] e;
  int bad_count = 0, check_count = 0;
  logic [5:0] ix[9] = '{shape_pkg::IDX_RESID_106, shape_pkg::IDX_KIND_106,
    shape_pkg::IDX_SHAPE_106, shape_pkg::IDX_LEN_106, shape_pkg::IDX_FLOOR_212,
    shape_pkg::IDX_KIND_212, shape_pkg::IDX_CTRL, shape_pkg::IDX_STATUS, 6'h3F};
  logic [7:0] rv[9] = '{shape_pkg::RST_RESID, shape_pkg::RST_KIND, shape_pkg::RST_SHAPE,
    shape_pkg::RST_LEN, 8'h00, shape_pkg::RST_KIND, shape_pkg::RST_CTRL, 8'h00, 8'h00};
  logic [7:0] mk[9] = '{8'hFF, 8'hFF, shape_pkg::SHAPE_MASK, shape_pkg::LEN_MASK,
    8'hFF, 8'hFF, shape_pkg::CTRL_MASK, 8'h00, 8'h00};

  always #20 clk = ~clk;

  typeb_tx_edge_shaper typeb_tx_edge_shaper_inst (.clk(clk), .reset(reset),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .mod_req(mod_req),
    .amplifier_supply_voltage(supply), .tx_amplitude(amp), .edge_active(act));
  pa_model pa_model_inst (.clk(clk), .tx_amplitude(amp), .supply_level(supply));

  function automatic logic [7:0] rnd();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed[7:0];
  endfunction

  task automatic fail(input string m);
    $display("CHECK FAILED %0t %s", $time, m);
    bad_count++;
  endtask

  task automatic tally_and_finish();
    if (bad_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] v, input logic s);
    int n;
    @(posedge clk);
    {cyc, stb, we} <= {2'b11, w};
    adr <= {i, 2'b00};
    dat_w <= {24'h000000, v};
    sel <= {3'h0, s};
    n = 0;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
    {cyc, stb, we} <= 3'b000;
    if (n >= 20) begin fail("bus timeout"); tally_and_finish(); end
  endtask

  task automatic rd(input logic [5:0] i, input logic [7:0] x);
    rq.push_back(x);
    bus(1'b0, i, 8'h00, 1'b1);
  endtask

  task automatic edge_run(input logic m, input logic [7:0] a, input logic [5:0] l);
    int n;
    aq.push_back({l, a});
    @(posedge clk) mod_req <= m;
    n = 0;
    while (aq.size() != 0 && n < 200) begin @(posedge clk); n++; end
    if (n >= 200) begin fail("edge timeout"); tally_and_finish(); end
    rd(shape_pkg::IDX_STATUS, m ? 8'h02 : 8'h00);
  endtask

  // Result watcher: read data on ack, final level and length on ramp end
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      check_count++;
      exp_r = rq.pop_front();
      if (dat_r !== {24'h000000, exp_r}) fail("read data mismatch");
    end
    if (act === 1'b1) begin
      act_len++;
      if ((amp < fl) !== 1'b0) fail("ramp below floor level");
    end else if (prev_act) begin
      check_count++;
      e = aq.pop_front();
      if (amp !== e[7:0] || act_len !== e[13:8]) fail("ramp end or length mismatch");
      act_len = 6'h00;
    end
    prev_act = act;
  end

  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    for (int k = 0; k < 9; k++) begin
      rd(ix[k], rv[k]);
      d = rnd();
      bus(1'b1, ix[k], d, 1'b1);
      bus(1'b1, ix[k], ~d, 1'b0);
      rd(ix[k], d & mk[k]);
    end
    for (int i = 0; i < 14; i++) begin
      code = 4'(i % 7 + 1);
      n5 = 5'(i * 5 % 31 + 1);
      x2 = i[0];
      fl = rnd();
      bus(1'b1, i < 7 ? shape_pkg::IDX_KIND_106 : shape_pkg::IDX_KIND_212, {code, code}, 1'b1);
      bus(1'b1, shape_pkg::IDX_SHAPE_106, rnd(), 1'b1);
      bus(1'b1, shape_pkg::IDX_LEN_106, {x2, 2'b00, n5}, 1'b1);
      bus(1'b1, i < 7 ? shape_pkg::IDX_RESID_106 : shape_pkg::IDX_FLOOR_212, fl, 1'b1);
      bus(1'b1, i < 7 ? shape_pkg::IDX_FLOOR_212 : shape_pkg::IDX_RESID_106, ~fl, 1'b1);
      bus(1'b1, shape_pkg::IDX_CTRL, {6'h00, i >= 7, 1'b1}, 1'b1);
      edge_run(1'b1, fl, x2 ? {n5, 1'b0} : {1'b0, n5});
      edge_run(1'b0, 8'hFF, x2 ? {n5, 1'b0} : {1'b0, n5});
    end
    bus(1'b1, shape_pkg::IDX_CTRL, 8'h00, 1'b1);
    mod_req <= 1'b1;
    repeat (20) @(posedge clk);
    check_count++;
    if (amp !== 8'hFF || act !== 1'b0) fail("modulated while disabled");
    mod_req <= 1'b0;
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule
